// ==== hw/ssm_pkg.sv ====
// ssm_pkg: shared constants and types for the serial memory slave and its master
// assumes: both ends run on core_clk at 100 MHz, link pins sampled in each end
package ssm_pkg;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DEPTH = 512;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_MASK = 8'hf7;
  localparam int unsigned OP_ABIT = 3;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam int unsigned ST_WEL = 1;
  localparam int unsigned ST_BP_LO = 2;
  localparam int unsigned ST_WPEN = 7;
  localparam real SCK_MAX_MHZ = 20.0;
  localparam int unsigned CLK_MHZ = 100;
  // half period of the generated serial clock, rounded up so the rate stays at most 20 MHz
  localparam int unsigned SCK_HALF_CYC = (CLK_MHZ + 2 * 20 - 1) / (2 * 20);
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int unsigned SYNC_RST = 0;

  typedef enum logic [2:0] {
    SSM_OPC = 3'h0,
    SSM_ADR = 3'h1,
    SSM_DAT = 3'h3,
    SSM_IGN = 3'h2,
    SSM_WST = 3'h6
  } ssm_phase_type;

  typedef enum logic [2:0] {
    SSM_M_IDLE = 3'h0,
    SSM_M_SEL = 3'h1,
    SSM_M_LOW = 3'h3,
    SSM_M_HIGH = 3'h2,
    SSM_M_DONE = 3'h6
  } ssm_mstate_type;
endpackage

// ==== hw/ssm_link_if.sv ====
// ssm_link_if: spi wires between master and memory slave
// assumes: testbench resolves the shared data line if si and so are joined
interface ssm_link_if;
  logic cs_b;
  logic sck;
  logic si;
  logic so_o;
  logic so_oe_b;
  logic suspend_b;
  logic write_protect_b;
  logic so;
  assign so = so_oe_b ? 1'b1 : so_o;
  modport slave (
    input cs_b, sck, si, suspend_b, write_protect_b,
    output so_o, so_oe_b
  );
  modport master (
    output cs_b, sck, si, suspend_b, write_protect_b,
    input so
  );
endinterface

// ==== hw/ssm_slave.sv ====
// ssm_slave: spi slave front end with a 512 x 8 array behind it
// assumes: link pins are asynchronous to core_clk; sck well below core_clk / 4
// What this block does
// - act only while select held low
// - select high: standby, ignore inputs, output floats
// - master issues one opcode per select
// - sample on sck rise, shift out on fall
// - any sck rate well below core_clk / 4, stoppable, state kept
// - serial input read only at sck rise
// - drive output only for read data
// - protect pin low blocks all writes
// - protect pin high: status bits decide writes
// - suspend low freezes, ignores sck and select
// - master changes suspend only while sck low
// - 512 bytes of eight bits, serial
// - nine-bit address, top bit in opcode
// - byte written at bus speed, no polling
// - first byte after select is opcode
// - bad opcode ignored until next select
// - msb first on every byte
// - sck level at select picks mode 0/3
module ssm_slave (
  input wire logic core_clk,
  input wire logic rst_b,
  ssm_link_if.slave link,
  output logic mode3_q,
  output logic [7:0] status_q
);
  typedef struct packed {
    logic [2:0] cs_s;
    logic [2:0] sck_s;
    logic [1:0] si_s;
    logic [1:0] sus_s;
    logic [1:0] wp_s;
    ssm_pkg::ssm_phase_type phase;
    logic [7:0] opcode;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic [8:0] addr;
    logic [7:0] status;
    logic mode3;
    logic rd_act;
    logic so;
    logic so_oe_b;
    logic [7:0] txreg;
  } ssm_sstate_type;

  logic [7:0] mem [ssm_pkg::DEPTH];
  ssm_sstate_type s_q, s_d;
  logic wr_en;
  logic [8:0] wr_addr;
  logic [7:0] wr_data;

  // bp field protects the upper quarter, half or whole array
  function automatic logic blocked(input logic [7:0] st, input logic [8:0] a);
    logic [1:0] bp;
    bp = st[ssm_pkg::ST_BP_LO +: 2];
    unique case (bp)
      2'h0: blocked = 1'b0;
      2'h1: blocked = a[8] & a[7];
      2'h2: blocked = a[8];
      default: blocked = 1'b1;
    endcase
  endfunction

  function automatic ssm_pkg::ssm_phase_type decode(input logic [7:0] op);
    logic [7:0] m;
    m = op & ssm_pkg::OP_MASK;
    if (m == ssm_pkg::OP_READ || m == ssm_pkg::OP_WRITE) decode = ssm_pkg::SSM_ADR;
    else if (op == ssm_pkg::OP_RDSR || op == ssm_pkg::OP_WRSR) decode = ssm_pkg::SSM_DAT;
    else if (op == ssm_pkg::OP_WREN || op == ssm_pkg::OP_WRDI) decode = ssm_pkg::SSM_WST;
    else decode = ssm_pkg::SSM_IGN;
  endfunction

  always_comb begin
    logic cs_fall, cs_hi, sck_rise, sck_fall, frozen, byte_done, wp_ok, is_read, is_write;
    logic [7:0] nb;
    s_d = s_q;
    wr_en = 1'b0;
    wr_addr = s_q.addr;
    wr_data = 8'h00;
    s_d.cs_s = {s_q.cs_s[1:0], link.cs_b};
    s_d.sck_s = {s_q.sck_s[1:0], link.sck};
    s_d.si_s = {s_q.si_s[0], link.si};
    s_d.sus_s = {s_q.sus_s[0], link.suspend_b};
    s_d.wp_s = {s_q.wp_s[0], link.write_protect_b};
    frozen = ~s_q.sus_s[1];
    cs_hi = s_q.cs_s[2];
    cs_fall = s_q.cs_s[2] & ~s_q.cs_s[1] & ~frozen;
    sck_rise = ~s_q.sck_s[2] & s_q.sck_s[1] & ~frozen & ~cs_hi;
    sck_fall = s_q.sck_s[2] & ~s_q.sck_s[1] & ~frozen & ~cs_hi;
    nb = {s_q.shreg[6:0], s_q.si_s[1]};
    byte_done = sck_rise && s_q.bitcnt == ssm_pkg::BIT_LAST;
    // protect pin low blocks every write on its own; the status bits only act while it is high
    wp_ok = s_q.wp_s[1];
    is_read = (s_q.opcode & ssm_pkg::OP_MASK) == ssm_pkg::OP_READ;
    is_write = (s_q.opcode & ssm_pkg::OP_MASK) == ssm_pkg::OP_WRITE;
    if (cs_hi && !frozen) begin
      s_d.phase = ssm_pkg::SSM_OPC;
      s_d.bitcnt = 3'h0;
      s_d.rd_act = 1'b0;
    end
    if (cs_fall) begin
      s_d.mode3 = s_q.sck_s[1];
      s_d.phase = ssm_pkg::SSM_OPC;
      s_d.bitcnt = 3'h0;
      s_d.rd_act = 1'b0;
    end else if (sck_rise && s_q.phase != ssm_pkg::SSM_IGN) begin
      s_d.shreg = nb;
      s_d.bitcnt = s_q.bitcnt + 3'h1;
    end
    if (byte_done) begin
      unique case (s_q.phase)
        ssm_pkg::SSM_OPC: begin
          s_d.opcode = nb;
          s_d.addr[8] = nb[ssm_pkg::OP_ABIT];
          s_d.phase = decode(nb);
          if (nb == ssm_pkg::OP_WREN) s_d.status[ssm_pkg::ST_WEL] = 1'b1;
          if (nb == ssm_pkg::OP_WRDI) s_d.status[ssm_pkg::ST_WEL] = 1'b0;
          if (nb == ssm_pkg::OP_RDSR) begin
            s_d.txreg = s_q.status;
            s_d.rd_act = 1'b1;
          end
        end
        ssm_pkg::SSM_ADR: begin
          s_d.addr[7:0] = nb;
          s_d.phase = ssm_pkg::SSM_DAT;
          if (is_read) begin
            s_d.txreg = mem[{s_q.addr[8], nb}];
            s_d.rd_act = 1'b1;
          end
        end
        ssm_pkg::SSM_DAT: begin
          if (is_read) begin
            s_d.addr = s_q.addr + 9'h001;
            s_d.txreg = mem[s_q.addr + 9'h001];
          end else if (is_write) begin
            // commit happens on the same edge that completes the byte
            wr_en = wp_ok & s_q.status[ssm_pkg::ST_WEL] & ~blocked(s_q.status, s_q.addr);
            wr_data = nb;
            s_d.addr = s_q.addr + 9'h001;
          end else if (s_q.opcode == ssm_pkg::OP_WRSR) begin
            if (wp_ok && s_q.status[ssm_pkg::ST_WEL]) begin
              s_d.status[ssm_pkg::ST_WPEN] = nb[ssm_pkg::ST_WPEN];
              s_d.status[ssm_pkg::ST_BP_LO +: 2] = nb[ssm_pkg::ST_BP_LO +: 2];
              s_d.status[ssm_pkg::ST_WEL] = 1'b0;
            end
            s_d.phase = ssm_pkg::SSM_WST;
          end else begin
            s_d.txreg = s_q.status;
          end
        end
        default: ;
      endcase
    end
    if (sck_fall && s_q.rd_act) begin
      s_d.so = s_q.txreg[3'h7 - s_q.bitcnt];
    end
    // mode 0 needs the msb before the first rise of the byte
    if (s_q.rd_act && s_q.bitcnt == 3'h0 && !sck_fall && !s_q.sck_s[1]) s_d.so = s_q.txreg[7];
    s_d.so_oe_b = ~(s_q.rd_act & ~cs_hi & ~frozen);
  end

  always_ff @(posedge core_clk) begin
    if (wr_en) mem[wr_addr] <= wr_data;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{cs_s: 3'h7, sck_s: 3'h0, si_s: 2'h0, sus_s: 2'h3, wp_s: 2'h3,
               phase: ssm_pkg::SSM_OPC, opcode: 8'h00, shreg: 8'h00, bitcnt: 3'h0,
               addr: 9'h000, status: ssm_pkg::STATUS_RST, mode3: 1'b0, rd_act: 1'b0,
               so: 1'b0, so_oe_b: 1'b1, txreg: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  assign link.so_o = s_q.so;
  assign link.so_oe_b = s_q.so_oe_b;
  assign mode3_q = s_q.mode3;
  assign status_q = s_q.status;
endmodule // ssm_slave

// ==== hw/ssm_master.sv ====
// ssm_master: spi master that runs one command per request
// assumes: user holds req until ack; so returns through the interface
module ssm_master (
  input wire logic core_clk,
  input wire logic rst_b,
  ssm_link_if.master link,
  input wire logic req,
  input wire logic [7:0] opcode,
  input wire logic [3:0] nbytes,
  input wire logic [31:0] tx_data,
  input wire logic mode3,
  input wire logic suspend_b,
  input wire logic write_protect_b,
  output logic ack_q,
  output logic [31:0] rx_q
);
  typedef struct packed {
    ssm_pkg::ssm_mstate_type st;
    logic [7:0] half;
    logic [5:0] bits;
    logic [39:0] sh;
    logic [31:0] rx;
    logic [1:0] so_s;
    logic cs_b;
    logic sck;
    logic si;
    logic ack;
    logic sus;
    logic mode3;
  } ssm_mst_type;
  ssm_mst_type m_q, m_d;

  always_comb begin
    logic tick;
    m_d = m_q;
    m_d.ack = 1'b0;
    m_d.so_s = {m_q.so_s[0], link.so};
    tick = m_q.half == 8'(ssm_pkg::SCK_HALF_CYC - 1);
    m_d.half = tick ? 8'h00 : m_q.half + 8'h01;
    unique case (m_q.st)
      ssm_pkg::SSM_M_IDLE: begin
        m_d.sck = mode3;
        m_d.mode3 = mode3;
        if (req) begin
          m_d.st = ssm_pkg::SSM_M_SEL;
          m_d.cs_b = 1'b0;
          m_d.sh = {opcode, tx_data};
          // opcode byte counts too, so a bare opcode still sends eight bits
          m_d.bits = 6'({nbytes, 3'h0}) + 6'h08;
          m_d.half = 8'h00;
        end
      end
      ssm_pkg::SSM_M_SEL: if (tick) begin
        m_d.st = ssm_pkg::SSM_M_LOW;
        m_d.sck = 1'b0;
        m_d.si = m_q.sh[39];
      end
      ssm_pkg::SSM_M_LOW: if (tick && m_q.sus) begin
        m_d.st = ssm_pkg::SSM_M_HIGH;
        m_d.sck = 1'b1;
        m_d.sh = {m_q.sh[38:0], 1'b0};
        m_d.bits = m_q.bits - 6'h01;
      end
      ssm_pkg::SSM_M_HIGH: if (tick) begin
        m_d.rx = {m_q.rx[30:0], m_q.so_s[1]};
        if (m_q.bits == 6'h00) begin
          m_d.st = ssm_pkg::SSM_M_DONE;
          m_d.sck = m_q.mode3;
        end else begin
          m_d.st = ssm_pkg::SSM_M_LOW;
          m_d.sck = 1'b0;
          m_d.si = m_q.sh[39];
        end
      end
      ssm_pkg::SSM_M_DONE: if (tick) begin
        m_d.cs_b = 1'b1;
        m_d.ack = 1'b1;
        m_d.st = ssm_pkg::SSM_M_IDLE;
      end
      default: m_d.st = ssm_pkg::SSM_M_IDLE;
    endcase
    // suspend moves only while sck is and stays low; a fresh half period after a change
    // lets the slave wake through its sync flops before the next rise
    if (!m_q.sck && !m_d.sck && m_d.sus != suspend_b) begin
      m_d.sus = suspend_b;
      m_d.half = 8'h00;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      m_q <= '{st: ssm_pkg::SSM_M_IDLE, half: 8'h00, bits: 6'h00, sh: 40'h0, rx: 32'h0,
               so_s: 2'h3, cs_b: 1'b1, sck: 1'b0, si: 1'b0, ack: 1'b0, sus: 1'b1,
               mode3: 1'b0};
    end else begin
      m_q <= m_d;
    end
  end

  assign link.cs_b = m_q.cs_b;
  assign link.sck = m_q.sck;
  assign link.si = m_q.si;
  assign link.suspend_b = m_q.sus;
  assign link.write_protect_b = write_protect_b;
  assign ack_q = m_q.ack;
  assign rx_q = m_q.rx;
endmodule // ssm_master

// ==== verification/ssm_checker.sv ====
// ssm_checker: wire-level properties of the link between master and slave
// assumes: instantiated in tb_top beside the interface, all on core_clk
module ssm_checker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic sck,
  input wire logic si,
  input wire logic so_o,
  input wire logic so_oe_b,
  input wire logic suspend_b,
  input wire logic write_protect_b,
  input wire logic so
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // slack of six cycles covers the pin sync (three flops for select, two for suspend) and the output flop
  chk_idle_float: assert property (cs_b [*6] |-> so_oe_b)
    else $error("slave drives output while unselected");
  chk_hold_float: assert property (!suspend_b [*6] |-> so_oe_b)
    else $error("slave drives output while suspended");
  chk_drive_selected: assert property ($fell(so_oe_b) |-> !cs_b && suspend_b)
    else $error("output enabled outside an active select");
  chk_out_steady_high: assert property (sck && $past(sck) && !so_oe_b |-> $stable(so_o))
    else $error("output bit changed while sck high");
  chk_in_steady_high: assert property (!cs_b && $changed(si) |-> !sck)
    else $error("input bit changed while sck high");
  chk_suspend_sck_low: assert property ($changed(suspend_b) |-> !sck)
    else $error("suspend changed while sck high");
  chk_sck_rate: assert property (!cs_b && $changed(sck) |=> $stable(sck) [*2])
    else $error("sck half period shorter than three cycles");
  chk_new_select: assert property ($rose(cs_b) |=> cs_b)
    else $error("select not released between commands");

  cover property ($fell(cs_b) && sck);
  cover property ($fell(so_oe_b));
  cover property ($fell(suspend_b));
endmodule // ssm_checker

// ==== verification/tb_top.sv ====
// tb_top: master and slave joined by the link, driven through the master's command port
// assumes: hw package, interface and both ends compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk;
  logic rst_b;
  logic req;
  logic [7:0] opcode;
  logic [3:0] nbytes;
  logic [31:0] tx_data;
  logic mode3;
  logic suspend_b;
  logic write_protect_b;
  logic ack_q;
  logic [31:0] rx_q;
  logic mode3_q;
  logic [7:0] status_q;
  int n_mismatch;
  int checks;

  ssm_link_if link_if ();
  ssm_master ssm_master_inst (.core_clk(core_clk), .rst_b(rst_b), .link(link_if), .req(req),
    .opcode(opcode), .nbytes(nbytes), .tx_data(tx_data), .mode3(mode3), .suspend_b(suspend_b),
    .write_protect_b(write_protect_b), .ack_q(ack_q), .rx_q(rx_q));
  ssm_slave ssm_slave_inst (.core_clk(core_clk), .rst_b(rst_b), .link(link_if),
    .mode3_q(mode3_q), .status_q(status_q));
  ssm_checker ssm_checker_inst (.core_clk(core_clk), .rst_b(rst_b), .cs_b(link_if.cs_b),
    .sck(link_if.sck), .si(link_if.si), .so_o(link_if.so_o), .so_oe_b(link_if.so_oe_b),
    .suspend_b(link_if.suspend_b), .write_protect_b(link_if.write_protect_b), .so(link_if.so));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic complete_run();
    if (n_mismatch == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // one command per select; the master releases select in the same cycle that it raises ack
  task automatic cmd(input logic [7:0] op, input logic [3:0] n, input logic [31:0] d);
    int i;
    opcode = op;
    nbytes = n;
    tx_data = d;
    req = 1'b1;
    for (i = 0; i < 3000; i++) begin
      @(posedge core_clk);
      #1;
      if (ack_q === 1'b1) break;
    end
    req = 1'b0;
    @(posedge core_clk);
    #1;
    if (i == 3000) begin
      n_mismatch++;
      $display("unexpected ack: expected 1 seen 0");
      complete_run();
    end
  endtask

  localparam logic [7:0] A8 = 8'h08;

  initial begin
    rst_b = 1'b0;
    req = 1'b0;
    opcode = 8'h00;
    nbytes = 4'h0;
    tx_data = 32'h0;
    mode3 = 1'b0;
    suspend_b = 1'b1;
    write_protect_b = 1'b1;
    n_mismatch = 0;
    checks = 0;
    repeat (5) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    cmd(ssm_pkg::OP_RDSR, 4'h1, 32'h0);
    cmp("status", 32'h0, {24'h0, rx_q[7:0]});
    cmd(ssm_pkg::OP_WREN, 4'h0, 32'h0);
    cmd(ssm_pkg::OP_RDSR, 4'h1, 32'h0);
    cmp("status", 32'h2, {24'h0, rx_q[7:0]});
    // top address 1ff then 000: burst must wrap
    cmd(ssm_pkg::OP_WRITE | A8, 4'h3, 32'hffa53c00);
    cmd(ssm_pkg::OP_READ | A8, 4'h3, 32'hff000000);
    cmp("read", 32'ha53c, {16'h0, rx_q[15:0]});
    cmd(ssm_pkg::OP_READ, 4'h2, 32'h00000000);
    cmp("read", 32'h3c, {24'h0, rx_q[7:0]});
    write_protect_b = 1'b0;
    cmd(ssm_pkg::OP_WREN, 4'h0, 32'h0);
    cmd(ssm_pkg::OP_WRITE | A8, 4'h2, 32'hff000000);
    write_protect_b = 1'b1;
    cmd(ssm_pkg::OP_READ | A8, 4'h2, 32'hff000000);
    cmp("read", 32'ha5, {24'h0, rx_q[7:0]});
    // unknown opcode: output floats and reads back as all ones
    cmd(8'hff, 4'h2, 32'h01020000);
    cmp("float", 32'hffff, {16'h0, rx_q[15:0]});
    mode3 = 1'b1;
    cmd(ssm_pkg::OP_READ, 4'h2, 32'h00000000);
    cmp("mode", 32'h1, {31'h0, mode3_q});
    cmp("read", 32'h3c, {24'h0, rx_q[7:0]});
    mode3 = 1'b0;
    cmd(ssm_pkg::OP_RDSR, 4'h1, 32'h0);
    cmp("mode", 32'h0, {31'h0, mode3_q});
    // suspend in mid-read; the transfer must resume intact
    fork
      cmd(ssm_pkg::OP_READ | A8, 4'h3, 32'hff000000);
      begin
        repeat (60) @(posedge core_clk);
        #1;
        suspend_b = 1'b0;
        repeat (40) @(posedge core_clk);
        #1;
        suspend_b = 1'b1;
      end
    join
    cmp("read", 32'ha53c, {16'h0, rx_q[15:0]});
    complete_run();
  end
endmodule // tb_top
